// ### rtl/mlfr_pkg.sv
// package: register map, field layout and timing constants of the lock fault response
package mlfr_pkg;
	localparam int unsigned CLK_HZ          = 20000000;
	// register byte offsets
	localparam logic [7:0]  CFG_OFF         = 8'h00;
	localparam logic [7:0]  CTRL_OFF        = 8'h04;
	localparam logic [7:0]  STAT_OFF        = 8'h08;
	localparam logic [7:0]  IRQ_STAT_OFF    = 8'h0c;
	localparam logic [7:0]  IRQ_MASK_OFF    = 8'h10;
	// config field positions
	localparam int          RETRY_LSB       = 7;
	localparam int          ACTION_LSB      = 3;
	localparam int          IPD_EN_BIT      = 2;
	localparam int          LIMIT_LSB       = 11;
	localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK       = 32'h0000_7ffc;
	// retry interval timing
	localparam int unsigned RETRY_BASE_MS   = 300;
	localparam int unsigned RETRY_500_MS    = 500;
	localparam int unsigned RETRY_STEP_MS   = 1000;
	localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
	// interrupt bits
	localparam int          IRQ_LOCK        = 0;
	localparam int          IRQ_RETRY       = 1;
	localparam int          IRQ_LATCH       = 2;
	localparam int          IRQ_IPD         = 3;

	typedef enum logic [1:0] {
		MLFR_IDLE  = 2'b00,
		MLFR_RETRY = 2'b01,
		MLFR_LATCH = 2'b11,
		MLFR_REPORT = 2'b10
	} mlfr_state_t;

	typedef struct packed {
		logic tristate;
		logic brake;
		logic fault;
	} mlfr_drive_t;
endpackage

// ### rtl/mlfr_motor_lock_fault_response.sv
// lock fault response: mode decode, retry timer, latching, apb registers, interrupt
// Overview of operation
// - retry interval code selects auto-clear delay
// - codes 0,1: latch, fault, tristate
// - codes 2,3: latch, fault, low-side brake
// - codes 4,5: tristate, retry, then latch
// - code 6: brake, retry without limit
// - code 7: brake, retry, latch past count
// - code 8: report fault, no action
// - codes 9,A,C: lock detection disabled
// - timeout fault only when enable set
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module mlfr_motor_lock_fault_response
	import mlfr_pkg::*;
#(
	parameter int unsigned MS_DIV = MS_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        lock_detect,
	input  wire logic        ipd_timeout,
	output logic             fault_n,
	output logic             gate_tristate,
	output logic             low_side_brake,
	output logic             irq
);
	logic [1:0]  lock_sync_reg;
	logic [1:0]  ipd_sync_reg;
	logic        ipd_seen_reg;
	logic [31:0] cfg_reg;
	logic [3:0]  irq_stat_reg;
	logic [3:0]  irq_mask_reg;
	mlfr_state_t state_reg;
	logic [3:0]  retries_reg;
	logic [3:0]  lock_mode_reg;
	logic [15:0] ms_cnt_reg;
	logic [13:0] ms_left_reg;
	logic        ipd_fault_reg;
	mlfr_drive_t drive_reg;

	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & ~pwrite;
	wire [3:0] action = cfg_reg[ACTION_LSB +: 4];
	wire [3:0] retry_code = cfg_reg[RETRY_LSB +: 4];
	wire [3:0] retry_limit = cfg_reg[LIMIT_LSB +: 4];
	wire lock_in = lock_sync_reg[1];
	wire ipd_in = ipd_sync_reg[1];
	wire mapped = paddr inside {CFG_OFF, CTRL_OFF, STAT_OFF, IRQ_STAT_OFF, IRQ_MASK_OFF};
	wire clear_wr = wr_en && paddr == CTRL_OFF && pwdata[0];

	function automatic logic [13:0] interval_ms(input logic [3:0] code);
		if (code == 4'h0) begin
			interval_ms = 14'(RETRY_BASE_MS);
		end else if (code == 4'h1) begin
			interval_ms = 14'(RETRY_500_MS);
		end else begin
			interval_ms = 14'((32'(code) - 32'd1) * RETRY_STEP_MS);
		end
	endfunction

	function automatic logic lock_enabled(input logic [3:0] m);
		lock_enabled = m <= 4'h8;
	endfunction

	wire lock_event = lock_in && lock_enabled(action) && state_reg == MLFR_IDLE;
	wire ms_tick = ms_cnt_reg == 16'(MS_DIV - 1);
	wire interval_done = state_reg == MLFR_RETRY && ms_tick && ms_left_reg <= 14'd1;
	// latch past limit; code 6 never latches
	wire over_limit = retries_reg >= retry_limit && lock_mode_reg != 4'h6;
	wire retry_clear = interval_done && !over_limit;
	wire retry_latch = interval_done && over_limit;
	wire ipd_event = ipd_in && !ipd_seen_reg && cfg_reg[IPD_EN_BIT];
	wire [3:0] irq_events = {ipd_event, retry_latch, retry_clear, lock_event};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_sync_reg <= 2'b00;
			ipd_sync_reg <= 2'b00;
			ipd_seen_reg <= 1'b0;
		end else begin
			lock_sync_reg <= {lock_sync_reg[0], lock_detect};
			ipd_sync_reg <= {ipd_sync_reg[0], ipd_timeout};
			ipd_seen_reg <= ipd_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= CFG_RESET;
			irq_mask_reg <= 4'h0;
		end else if (wr_en && paddr == CFG_OFF) begin
			cfg_reg <= pwdata & CFG_WMASK;
		end else if (wr_en && paddr == IRQ_MASK_OFF) begin
			irq_mask_reg <= pwdata[3:0];
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 4'h0;
		end else if (wr_en && paddr == IRQ_STAT_OFF) begin
			irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_events;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ipd_fault_reg <= 1'b0;
		end else if (ipd_event) begin
			ipd_fault_reg <= 1'b1;
		end else if (clear_wr) begin
			ipd_fault_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_reg <= 16'h0000;
		end else if (state_reg != MLFR_RETRY || ms_tick) begin
			ms_cnt_reg <= 16'h0000;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= MLFR_IDLE;
			retries_reg <= 4'h0;
			lock_mode_reg <= 4'h0;
			ms_left_reg <= 14'h0000;
		end else begin
			case (state_reg)
				MLFR_IDLE: begin
					if (lock_event) begin
						lock_mode_reg <= action;
						ms_left_reg <= interval_ms(retry_code);
						if (action <= 4'h3) begin
							state_reg <= MLFR_LATCH;
						end else if (action == 4'h8) begin
							state_reg <= MLFR_REPORT;
						end else begin
							state_reg <= MLFR_RETRY;
						end
					end else if (clear_wr) begin
						retries_reg <= 4'h0;
					end
				end
				MLFR_RETRY: begin
					if (clear_wr) begin
						state_reg <= MLFR_IDLE;
						retries_reg <= 4'h0;
					end else if (ms_tick) begin
						ms_left_reg <= ms_left_reg - 14'd1;
						if (retry_clear) begin
							state_reg <= MLFR_IDLE;
							if (retries_reg != 4'hf) begin
								retries_reg <= retries_reg + 4'h1;
							end
						end else if (retry_latch) begin
							state_reg <= MLFR_LATCH;
						end
					end
				end
				MLFR_LATCH, MLFR_REPORT: begin
					if (clear_wr) begin
						state_reg <= MLFR_IDLE;
						retries_reg <= 4'h0;
					end
				end
				default: begin
					state_reg <= MLFR_IDLE;
				end
			endcase
		end
	end

	wire active = state_reg == MLFR_RETRY || state_reg == MLFR_LATCH;
	wire mode_brake = lock_mode_reg == 4'h2 || lock_mode_reg == 4'h3 ||
		lock_mode_reg == 4'h6 || lock_mode_reg == 4'h7;
	mlfr_drive_t drive_next;
	assign drive_next = '{tristate: active && !mode_brake,
		brake: active && mode_brake,
		fault: state_reg != MLFR_IDLE || ipd_fault_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign fault_n = ~drive_reg.fault;
	assign gate_tristate = drive_reg.tristate;
	assign low_side_brake = drive_reg.brake;
	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	wire [31:0] status_word = {20'h0, retries_reg, ipd_fault_reg, drive_reg.brake,
		drive_reg.tristate, drive_reg.fault, 2'b00, state_reg};
	wire [31:0] rd_mux = paddr == CFG_OFF ? cfg_reg :
		paddr == STAT_OFF ? status_word :
		paddr == IRQ_STAT_OFF ? {28'h0, irq_stat_reg} :
		paddr == IRQ_MASK_OFF ? {28'h0, irq_mask_reg} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_en && !penable) begin
			prdata <= rd_mux;
		end
	end

	a_latch_tristate: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_LATCH && !mode_brake |=> gate_tristate && !fault_n)
		else $error("latched tristate mode not driving tristate");
	a_latch_brake: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_LATCH && mode_brake |=> low_side_brake && !gate_tristate)
		else $error("brake mode not braking");
	a_report_only: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_REPORT |=> !gate_tristate && !low_side_brake && !fault_n)
		else $error("report mode took action");
	a_disabled_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_IDLE && !lock_enabled(action) |=> state_reg == MLFR_IDLE)
		else $error("disabled mode reacted to lock");
	a_ipd_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!cfg_reg[IPD_EN_BIT] && !ipd_fault_reg |=> !ipd_fault_reg)
		else $error("timeout fault raised while disabled");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_LATCH && !clear_wr |=> state_reg == MLFR_LATCH)
		else $error("latched fault released without clear");
	sequence s_retry_end;
		state_reg == MLFR_RETRY && retry_clear;
	endsequence
	a_retry_clear: assert property (@(posedge pclk) disable iff (!presetn)
		s_retry_end |=> state_reg == MLFR_IDLE ##1
		fault_n || state_reg != MLFR_IDLE || $past(ipd_fault_reg))
		else $error("auto clear did not release fault");
	a_mode6_nolatch: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_RETRY && lock_mode_reg == 4'h6 |=> state_reg != MLFR_LATCH)
		else $error("mode 6 latched");
	// interval loaded with exactly the coded time
	a_interval_len: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == MLFR_RETRY) |->
		ms_left_reg == interval_ms($past(retry_code)))
		else $error("retry interval mismatch");
	a_limit_latch: assert property (@(posedge pclk) disable iff (!presetn)
		retry_latch && !clear_wr |=> state_reg == MLFR_LATCH)
		else $error("retry limit did not latch");
	sequence s_lock_seen;
		state_reg == MLFR_IDLE && lock_event;
	endsequence
	a_lock_response: assert property (@(posedge pclk) disable iff (!presetn)
		s_lock_seen |=> state_reg != MLFR_IDLE ##1 !fault_n)
		else $error("lock event did not raise fault");
	a_retry_tristate: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_RETRY && !mode_brake |=>
		gate_tristate && !low_side_brake && !fault_n)
		else $error("tristate retry mode not tristating");
	a_retry_brake: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_RETRY && mode_brake |=>
		low_side_brake && !gate_tristate && !fault_n)
		else $error("brake retry mode not braking");
	a_ipd_raise: assert property (@(posedge pclk) disable iff (!presetn)
		ipd_event |=> ipd_fault_reg ##1 !fault_n)
		else $error("enabled timeout did not raise fault");
	a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
		!(gate_tristate && low_side_brake))
		else $error("brake and tristate together");
	a_idle_release: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == MLFR_IDLE && !ipd_fault_reg |=>
		fault_n && !gate_tristate && !low_side_brake)
		else $error("idle state still driving a fault");
endmodule // mlfr_motor_lock_fault_response

// ### verif/mlfr_gate_model.sv
// gate stage model: reports what the half-bridges do for the drive state
`timescale 1ns/1ps
module mlfr_gate_model (
	input  wire logic       gate_tristate,
	input  wire logic       low_side_brake,
	output logic      [1:0] phase_mode
);
	// bit1 high impedance, bit0 low-side braking, both set is an illegal overlap
	assign phase_mode = {gate_tristate, low_side_brake};
endmodule // mlfr_gate_model

// ### verif/tb_motor_lock_fault_response.sv
// self-checking bench for the lock fault response block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got %h want %h", $time, a, e); end end
module tb_motor_lock_fault_response
	import mlfr_pkg::*;
;
	localparam int MD = 4;
	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0000_0000;
	logic        lock_detect = 1'b0;
	logic        ipd_timeout = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic        pready, pslverr, last_err, fault_n, gate_tristate, low_side_brake, irq;
	logic [1:0]  phase_mode;
	int          failures     = 0;
	int          total_checks = 0;
	int          ivn;
	logic [3:0]  irq_want;
	logic [3:0]  codes [8]  = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hc};
	logic [3:0]  rmodes [3] = '{4'h4, 4'h6, 4'h7};

	always #25 pclk = ~pclk;

	mlfr_motor_lock_fault_response #(.MS_DIV(MD)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lock_detect(lock_detect),
		.ipd_timeout(ipd_timeout), .fault_n(fault_n), .gate_tristate(gate_tristate),
		.low_side_brake(low_side_brake), .irq(irq));
	mlfr_gate_model gate (.gate_tristate(gate_tristate), .low_side_brake(low_side_brake),
		.phase_mode(phase_mode));

	// expected {fault_n, tristate, brake} while a lock fault is active
	function automatic logic [2:0] drv(input logic [3:0] c);
		if (c <= 4'h1 || c == 4'h4 || c == 4'h5) return 3'b010;
		if (c <= 4'h7) return 3'b001;
		if (c == 4'h8) return 3'b000;
		return 3'b100;
	endfunction

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata    = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic pulse(input bit pos);
		@(posedge pclk);
		if (pos) ipd_timeout <= 1'b1; else lock_detect <= 1'b1;
		repeat (8) @(posedge pclk);
		ipd_timeout <= 1'b0;
		lock_detect <= 1'b0;
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, CFG_OFF, 32'h0);
		`CHK(rdata, CFG_RESET)
		xfer(1'b0, 8'h40, 32'h0);
		`CHK(last_err, 1'b1)
		xfer(1'b1, CFG_OFF, 32'hffff_ffff);
		xfer(1'b0, CFG_OFF, 32'h0);
		`CHK(rdata, CFG_WMASK)
		$display("test registers done");
		xfer(1'b1, IRQ_MASK_OFF, 32'h1 << IRQ_LOCK);
		foreach (codes[i]) begin
			xfer(1'b1, CFG_OFF, 32'(codes[i]) << ACTION_LSB);
			pulse(1'b0);
			wt(1);
			`CHK({fault_n, phase_mode}, drv(codes[i]))
			`CHK(irq, codes[i] <= 4'h8)
			wt(100);
			`CHK({fault_n, phase_mode}, drv(codes[i]))
			xfer(1'b1, CTRL_OFF, 32'h1);
			xfer(1'b1, IRQ_STAT_OFF, 32'h1 << IRQ_LOCK);
			wt(3);
			`CHK({fault_n, phase_mode}, 3'b100)
			`CHK(irq, 1'b0)
		end
		$display("test action codes done");
		foreach (rmodes[i]) begin
			ivn = (i == 0) ? RETRY_BASE_MS * MD :
				(i == 1) ? RETRY_500_MS * MD : RETRY_STEP_MS * MD;
			xfer(1'b1, CTRL_OFF, 32'h1);
			xfer(1'b1, IRQ_STAT_OFF, 32'hf);
			xfer(1'b1, CFG_OFF, (32'h1 << LIMIT_LSB) | (32'(i) << RETRY_LSB)
				| (32'(rmodes[i]) << ACTION_LSB));
			pulse(1'b0);
			wt(ivn - 40);
			`CHK({fault_n, phase_mode}, drv(rmodes[i]))
			wt(60);
			`CHK({fault_n, phase_mode}, 3'b100)
			pulse(1'b0);
			wt(ivn + 20);
			`CHK({fault_n, phase_mode}, (i == 1) ? 3'b100 : drv(rmodes[i]))
			irq_want = 4'((1 << IRQ_LOCK) | (1 << IRQ_RETRY)
				| (int'(i != 1) << IRQ_LATCH));
			xfer(1'b0, IRQ_STAT_OFF, 32'h0);
			`CHK(rdata[3:0], irq_want)
			xfer(1'b0, STAT_OFF, 32'h0);
			`CHK(rdata[11:8], (i == 1) ? 4'h2 : 4'h1)
		end
		$display("test retry modes done");
		xfer(1'b1, CTRL_OFF, 32'h1);
		xfer(1'b1, IRQ_STAT_OFF, 32'hf);
		xfer(1'b1, IRQ_MASK_OFF, 32'h1 << IRQ_IPD);
		xfer(1'b1, CFG_OFF, 32'h0);
		pulse(1'b1);
		wt(4);
		`CHK(irq, 1'b0)
		xfer(1'b0, STAT_OFF, 32'h0);
		`CHK(rdata[7], 1'b0)
		xfer(1'b1, CFG_OFF, 32'h1 << IPD_EN_BIT);
		pulse(1'b1);
		wt(4);
		`CHK(irq, 1'b1)
		xfer(1'b0, STAT_OFF, 32'h0);
		`CHK(rdata[7], 1'b1)
		xfer(1'b1, IRQ_STAT_OFF, 32'h1 << IRQ_IPD);
		wt(2);
		`CHK(irq, 1'b0)
		$display("test timeout fault done");
		conclude();
	end

	// about three times the expected run
	initial begin
		repeat (50000) @(posedge pclk);
		failures++;
		conclude();
	end
endmodule // tb_motor_lock_fault_response
